// ### overtemp_timer_limit.sv
// Overtemperature assertion timer limit compare and fan pulse-count configuration
//
// Behaviour
// - Eight-bit writable limit, one step equals 22.76 ms of assertion.
// - Limit covers 45.52 ms to 5.80 s of continuous assertion.
// - Assertion time beyond limit sets bit 5 of register 0x42; a limit of 0xff never sets it, as the count saturates at 0xff.
// - Zero limit raises the flag immediately when the line asserts.
// - Limit register reads zero after reset.
// - Bits 1:0 select first fan pulses, codes mean one to four.
// - Bits 3:2 select second fan pulses, same encoding.
// - Bits 5:4 select third fan pulses, same encoding.
// - Bits 7:6 select fourth fan pulses, same encoding.
// - Pulse-count register resets to 0x55, two pulses per fan.
// - Seen bit sets on assertion, clears when timer status is read.
// - Upper timer bits zero until 45.52 ms, then full count shown.
`timescale 1ns/1ns
`default_nettype none
module overtemp_timer_limit #(
    parameter int STEP_CYCLES = otl_pkg::STEP_CYCLES
) (
    // Clock, reset, enable
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic CE,
    // Overtemperature line from the pin, active low
    input wire logic OVERTEMP_LINE_N,
    // Register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // Configuration and status toward the fan and interrupt logic
    output logic [1:0] FIRST_FAN_PULSE_SEL,
    output logic [1:0] SECOND_FAN_PULSE_SEL,
    output logic [1:0] THIRD_FAN_PULSE_SEL,
    output logic [1:0] FOURTH_FAN_PULSE_SEL,
    output logic OVERTEMP_TIME_FLAG,
    output logic [7:0] ASSERT_DURATION_COUNT
);
    // Pin synchroniser and accepted level
    logic [2:0] sync_r;
    logic line_r;
    logic line_prev_r;
    // Timer, flags and register state
    logic [31:0] presc_r;
    logic [7:0] count_r;
    logic seen_r;
    logic flag_r;
    logic fired_r;
    logic [7:0] limit_r;
    logic [7:0] pulse_cfg_r;
    // Combinational helpers
    logic [7:0] rdata_nxt;
    logic [7:0] timer_view;
    logic rise;
    logic step_done;
    logic over_limit;
    logic rd_status;
    logic rd_int;
    logic limit_zero;
    logic count_over;

    // Address decode shared by the strobe qualifiers and the write path
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // Two-bit pulse selection of one fan; code n counts n+1 pulses
    function automatic logic [1:0] fan_field(input logic [7:0] cfg, input int lsb);
        return cfg[lsb +: 2];
    endfunction

    // Pin passes three flops; a level counts only once the last two agree
    // Reset loads the released level, so no false edge follows reset
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            sync_r <= 3'h7;
            line_r <= 1'b0;
            line_prev_r <= 1'b0;
        end else if (CE) begin
            sync_r <= {sync_r[1:0], OVERTEMP_LINE_N};
            if (sync_r[1] == sync_r[2]) begin
                line_r <= ~sync_r[2];
            end
            line_prev_r <= line_r;
        end
    end

    // One-cycle pulse on each accepted assertion
    assign rise = line_r & ~line_prev_r;
    // Last prescaler cycle of one 22.76 ms step
    assign step_done = (presc_r == 32'(STEP_CYCLES - 1));
    // Read side effects by address; CE gating sits in the processes
    assign rd_status = REG_RD && addr_is(REG_ADDR, otl_pkg::TIMER_STATUS_ADDR);
    assign rd_int = REG_RD && addr_is(REG_ADDR, otl_pkg::INT_STATUS2_ADDR);

    // Duration counter: one step per 22.76 ms, restarts on each new assertion
    // Saturates at the top so a long assertion cannot wrap and re-arm the compare
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            presc_r <= 32'h0;
            count_r <= 8'h00;
        end else if (CE) begin
            if (rise) begin
                presc_r <= 32'h0;
                count_r <= 8'h00;
            end else if (line_r) begin
                presc_r <= step_done ? 32'h0 : presc_r + 32'h1;
                if (step_done && count_r != otl_pkg::COUNT_MAX) begin
                    count_r <= count_r + 8'h01;
                end
            end
        end
    end

    // Seen bit: a new assertion in the read cycle wins over the clear
    // Clearing on read lets software notice each new episode once
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            seen_r <= 1'b0;
        end else if (CE) begin
            if (rise) begin
                seen_r <= 1'b1;
            end else if (rd_status) begin
                seen_r <= 1'b0;
            end
        end
    end

    // Below two steps only the seen bit shows; beyond, the full count
    assign timer_view = (count_r >= otl_pkg::VISIBLE_STEPS) ? count_r :
                        {7'h00, seen_r};

    // Zero limit means fire on the accepted assertion edge itself
    assign limit_zero = (limit_r == 8'h00);
    // The rise cycle still carries the count held from the last episode, so it is masked
    assign count_over = line_r && !rise && (count_r > limit_r);
    // Zero limit fires on the edge; otherwise when the count passes the limit
    assign over_limit = limit_zero ? rise : count_over;

    // Sticky flag, cleared by reading the interrupt status; set wins
    // fired_r blocks a second set in one episode once software has cleared the flag
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            flag_r <= 1'b0;
            fired_r <= 1'b0;
        end else if (CE) begin
            if (rise) begin
                fired_r <= limit_zero;
            end else if (over_limit) begin
                fired_r <= 1'b1;
            end
            if (over_limit && (!fired_r || rise)) begin
                flag_r <= 1'b1;
            end else if (rd_int) begin
                flag_r <= 1'b0;
            end
        end
    end

    // Writable registers; other addresses ignore writes
    // Status addresses are read-only here, so writes to them fall through
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            limit_r <= otl_pkg::TIME_LIMIT_RST;
            pulse_cfg_r <= otl_pkg::PULSE_CFG_RST;
        end else if (CE && REG_WR) begin
            if (addr_is(REG_ADDR, otl_pkg::TIME_LIMIT_ADDR)) begin
                limit_r <= REG_WDATA;
            end
            if (addr_is(REG_ADDR, otl_pkg::PULSE_CFG_ADDR)) begin
                pulse_cfg_r <= REG_WDATA;
            end
        end
    end

    // Read mux; unmapped addresses read zero
    // Read side effects act at the strobe edge; the data registered at that same edge holds the values from before them
    always_comb begin
        rdata_nxt = 8'h00;
        case (REG_ADDR)
            otl_pkg::INT_STATUS2_ADDR: begin
                rdata_nxt[otl_pkg::TIME_FLAG_BIT] = flag_r;
            end
            otl_pkg::TIMER_STATUS_ADDR: begin
                rdata_nxt = timer_view;
            end
            otl_pkg::TIME_LIMIT_ADDR: begin
                rdata_nxt = limit_r;
            end
            otl_pkg::PULSE_CFG_ADDR: begin
                rdata_nxt = pulse_cfg_r;
            end
            default: begin
                rdata_nxt = 8'h00;
            end
        endcase
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            REG_RDATA <= otl_pkg::STATUS_RST;
            REG_RVALID <= 1'b0;
        end else if (CE) begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= rdata_nxt;
            end
        end
    end

    // Field outputs; code n means n+1 pulses per measurement
    // Turning the code into a pulse count is left to the fan measurement logic
    assign FIRST_FAN_PULSE_SEL = fan_field(pulse_cfg_r, otl_pkg::FIRST_FAN_PULSE_SEL_LSB);
    assign SECOND_FAN_PULSE_SEL = fan_field(pulse_cfg_r, otl_pkg::SECOND_FAN_PULSE_SEL_LSB);
    assign THIRD_FAN_PULSE_SEL = fan_field(pulse_cfg_r, otl_pkg::THIRD_FAN_PULSE_SEL_LSB);
    assign FOURTH_FAN_PULSE_SEL = fan_field(pulse_cfg_r, otl_pkg::FOURTH_FAN_PULSE_SEL_LSB);
    assign OVERTEMP_TIME_FLAG = flag_r;
    assign ASSERT_DURATION_COUNT = timer_view;
endmodule
`default_nettype wire

// ### otl_pkg.sv
// Constants for the overtemperature timer limit and fan pulse configuration block
package otl_pkg;
    // Register offsets
    localparam logic [7:0] INT_STATUS2_ADDR = 8'h42;
    localparam logic [7:0] TIMER_STATUS_ADDR = 8'h79;
    localparam logic [7:0] TIME_LIMIT_ADDR = 8'h7a;
    localparam logic [7:0] PULSE_CFG_ADDR = 8'h7b;
    // Field positions
    localparam int TIME_FLAG_BIT = 5;
    localparam int FIRST_FAN_PULSE_SEL_LSB = 0;
    localparam int SECOND_FAN_PULSE_SEL_LSB = 2;
    localparam int THIRD_FAN_PULSE_SEL_LSB = 4;
    localparam int FOURTH_FAN_PULSE_SEL_LSB = 6;
    // Reset values
    localparam logic [7:0] TIME_LIMIT_RST = 8'h00;
    localparam logic [7:0] PULSE_CFG_RST = 8'h55;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // Timing: one count step of assertion time, and the clock period
    localparam int STEP_NS = 22760000;
    localparam int CLOCK_NS = 100;
    localparam int STEP_CYCLES = STEP_NS / CLOCK_NS;
    // Steps before the upper timer bits become visible (45.52 ms)
    localparam logic [7:0] VISIBLE_STEPS = 8'h02;
    localparam logic [7:0] COUNT_MAX = 8'hff;
endpackage

// ### otl_chk.sv
// Port assertions for the overtemperature limit block
`timescale 1ns/1ns
`default_nettype none
module otl_chk (
    // Clock, reset, enable
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic CE,
    // Pin and register port
    input wire logic OVERTEMP_LINE_N,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    // Configuration and status
    input wire logic [1:0] FIRST_FAN_PULSE_SEL,
    input wire logic [1:0] SECOND_FAN_PULSE_SEL,
    input wire logic [1:0] THIRD_FAN_PULSE_SEL,
    input wire logic [1:0] FOURTH_FAN_PULSE_SEL,
    input wire logic OVERTEMP_TIME_FLAG,
    input wire logic [7:0] ASSERT_DURATION_COUNT
);
    logic [7:0] lim_r;
    logic cfg_wr;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    // Shadow of the limit, since the block does not show it on a port
    always_ff @(posedge CLOCK) begin
        if (SRST) lim_r <= 8'h00;
        else if (CE && REG_WR && REG_ADDR == 8'h7a) lim_r <= REG_WDATA;
    end
    assign cfg_wr = CE && REG_WR && REG_ADDR == 8'h7b;
    chk_fan_one: assert property (cfg_wr |=> FIRST_FAN_PULSE_SEL == $past(REG_WDATA[1:0]))
        else $error("fan one select wrong");
    chk_fan_two: assert property (cfg_wr |=> SECOND_FAN_PULSE_SEL == $past(REG_WDATA[3:2]))
        else $error("fan two select wrong");
    chk_fan_three: assert property (cfg_wr |=> THIRD_FAN_PULSE_SEL == $past(REG_WDATA[5:4]))
        else $error("fan three select wrong");
    chk_fan_four: assert property (cfg_wr |=> FOURTH_FAN_PULSE_SEL == $past(REG_WDATA[7:6]))
        else $error("fan four select wrong");
    chk_limit_read: assert property (CE && REG_RD && REG_ADDR == 8'h7a |=> REG_RDATA == $past(lim_r))
        else $error("limit readback wrong");
    chk_read_valid: assert property (CE |=> REG_RVALID == $past(REG_RD))
        else $error("read valid timing wrong");
    // Flag may only rise on a zero limit or a count beyond the limit
    chk_flag_cause: assert property ($rose(OVERTEMP_TIME_FLAG) |-> $past(lim_r) == 8'h00 || $past(ASSERT_DURATION_COUNT) > $past(lim_r))
        else $error("flag rose without cause");
    chk_count_held: assert property (OVERTEMP_LINE_N [*6] ##0 !(REG_RD && REG_ADDR == 8'h79) |=> $stable(ASSERT_DURATION_COUNT))
        else $error("count moved while idle");
endmodule
bind overtemp_timer_limit otl_chk chk (
    .CLOCK(CLOCK),
    .SRST(SRST),
    .CE(CE),
    .OVERTEMP_LINE_N(OVERTEMP_LINE_N),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID),
    .FIRST_FAN_PULSE_SEL(FIRST_FAN_PULSE_SEL),
    .SECOND_FAN_PULSE_SEL(SECOND_FAN_PULSE_SEL),
    .THIRD_FAN_PULSE_SEL(THIRD_FAN_PULSE_SEL),
    .FOURTH_FAN_PULSE_SEL(FOURTH_FAN_PULSE_SEL),
    .OVERTEMP_TIME_FLAG(OVERTEMP_TIME_FLAG),
    .ASSERT_DURATION_COUNT(ASSERT_DURATION_COUNT)
);
`default_nettype wire

// ### otl_line.sv
// Far-side model of the overtemperature pin
`timescale 1ns/1ns
`default_nettype none
module otl_line (
    input wire logic CLOCK,
    input wire logic hot,
    output logic OVERTEMP_LINE_N
);
    // Pulled-up pin: released means high, so it idles deasserted
    // Unknown only before the first edge, which the design's reset covers
    always @(posedge CLOCK) OVERTEMP_LINE_N <= !hot;
endmodule
`default_nettype wire

// ### tb.sv
// Testbench for the overtemperature limit block
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic CLOCK = 1'b0, SRST = 1'b1, wr_s = 1'b0, rd_s = 1'b0, hot = 1'b0, ce = 1'b1;
    logic line_n, rv, flag;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, cnt, d;
    logic [1:0] sel [4];
    int fail_count = 0, comparisons = 0;
    always #50 CLOCK = ~CLOCK;
    otl_line far (.CLOCK(CLOCK), .hot(hot), .OVERTEMP_LINE_N(line_n));
    overtemp_timer_limit #(.STEP_CYCLES(4)) dut (.CLOCK(CLOCK), .SRST(SRST), .CE(ce),
        .OVERTEMP_LINE_N(line_n), .REG_WR(wr_s), .REG_RD(rd_s), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rv),
        .FIRST_FAN_PULSE_SEL(sel[0]), .SECOND_FAN_PULSE_SEL(sel[1]),
        .THIRD_FAN_PULSE_SEL(sel[2]), .FOURTH_FAN_PULSE_SEL(sel[3]),
        .OVERTEMP_TIME_FLAG(flag), .ASSERT_DURATION_COUNT(cnt));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Strobes are one-cycle pulses set with address and data; nothing waits for them to be taken
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge CLOCK);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge CLOCK);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CLOCK);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge CLOCK);
        rd_s <= 1'b0;
        #1 cmp({7'h00, rv}, 8'h01);
        cmp(rdata, exp);
    endtask
    task automatic finish_test;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog well beyond the 125 or so cycles the tests need
    initial begin
        #500000;
        fail_count++;
        finish_test;
    end
    initial begin
        repeat (16) @(posedge CLOCK);
        SRST <= 1'b0;
        rd(8'h7a, 8'h00);
        rd(8'h7b, 8'h55);
        rd(8'h10, 8'h00);
        for (int c = 0; c < 4; c++) begin
            d = {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)};
            wr(8'h7b, d);
            rd(8'h7b, d);
            for (int f = 0; f < 4; f++) cmp({6'h00, sel[f]}, {6'h00, 2'(c + f)});
        end
        // Zero limit fires on assertion, once per episode
        @(posedge CLOCK) hot <= 1'b1;
        repeat (8) @(posedge CLOCK);
        #1 cmp({7'h00, flag}, 8'h01);
        rd(8'h42, 8'h20);
        repeat (6) @(posedge CLOCK);
        #1 cmp({7'h00, flag}, 8'h00);
        @(posedge CLOCK) hot <= 1'b0;
        repeat (10) @(posedge CLOCK);
        wr(8'h7a, 8'h03);
        rd(8'h7a, 8'h03);
        @(posedge CLOCK) hot <= 1'b1;
        repeat (6) @(posedge CLOCK);
        rd(8'h79, 8'h01);
        rd(8'h79, 8'h00);
        repeat (8) @(posedge CLOCK);
        #1 cmp({7'h00, flag}, 8'h00);
        repeat (8) @(posedge CLOCK);
        #1 cmp({7'h00, flag}, 8'h01);
        cmp(cnt, 8'h05);
        rd(8'h79, 8'h05);
        rd(8'h42, 8'h20);
        repeat (4) @(posedge CLOCK);
        #1 cmp({7'h00, flag}, 8'h00);
        @(posedge CLOCK) hot <= 1'b0;
        repeat (12) @(posedge CLOCK);
        // A write while the enable is low must not land
        @(posedge CLOCK) ce <= 1'b0;
        wr(8'h7b, 8'hff);
        @(posedge CLOCK) ce <= 1'b1;
        rd(8'h7b, 8'h93);
        finish_test;
    end
endmodule
`default_nettype wire
